// [rtl/mp_pin_regs.sv]
// axi4-lite register block for pin values, pin config and pdm mic control
// assumes one clock, synchronous active-low reset, bus master per axi4-lite
`timescale 1ns/1ps
module mp_pin_regs
  import mp_pin_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [PINS-1:0] pin_level_in,
  output logic [PINS-1:0] core_value_out,
  output logic [PINS-1:0] multipurpose_select_out,
  output logic [3*PINS-1:0] pin_function_select_out,
  output logic [15:0] pdm_mic_control_ch01_out,
  output logic [15:0] pdm_mic_control_ch23_out,
  output logic [1:0] highpass_enable_out,
  output logic [5:0] highpass_corner_out
);
  initial begin
    if (PINS != NUM_PINS) begin
      $error("pin count must match register map");
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_WRITE_VALUE = 3'b001,
    SEL_READ_VALUE = 3'b010,
    SEL_CONFIG = 3'b011,
    SEL_PDM = 3'b100
  } sel_t;

  function automatic sel_t decode(input logic [ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx >= WRITE_VALUE_BASE_IDX && idx <= WRITE_VALUE_LAST_IDX) begin
      return SEL_WRITE_VALUE;
    end else if (idx >= READ_VALUE_BASE_IDX && idx <= READ_VALUE_LAST_IDX) begin
      return SEL_READ_VALUE;
    end else if (idx >= PIN_CONFIG_BASE_IDX && idx <= PIN_CONFIG_LAST_IDX) begin
      return SEL_CONFIG;
    end else if (idx == PDM_CH01_IDX || idx == PDM_CH23_IDX) begin
      return SEL_PDM;
    end
    return SEL_NONE;
  endfunction

  function automatic logic [3:0] pin_of(input logic [ADDR_W-1:0] a);
    return a[5:2];
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_RESP = 3'b010,
    W_HOLD = 3'b100
  } wstate_t;

  wstate_t wstate_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_have_reg;
  logic do_write;
  sel_t wsel;
  logic [3:0] wpin;
  logic [PINS-1:0] override_value;
  logic [PINS-1:0] sampled;
  logic [15:0] pdm_reg [2];
  logic [3:0] cfg_reg [PINS];

  assign s_axi_awready_out = (wstate_reg == W_IDLE) && !aw_have_reg;
  assign s_axi_wready_out = (wstate_reg == W_IDLE) && !w_have_reg;
  assign do_write = (wstate_reg == W_IDLE) && aw_have_reg && w_have_reg;
  assign wsel = decode(awaddr_reg);
  assign wpin = pin_of(awaddr_reg);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_in;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wstate_reg <= W_IDLE;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      case (wstate_reg)
        W_IDLE: begin
          if (do_write) begin
            wstate_reg <= W_RESP;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wsel == SEL_NONE || wsel == SEL_READ_VALUE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        W_RESP: begin
          if (s_axi_bready_in) begin
            wstate_reg <= W_IDLE;
            s_axi_bvalid_out <= 1'b0;
          end
        end
        default: begin
          wstate_reg <= W_IDLE;
          s_axi_bvalid_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  mp_value_bank #(
    .DEPTH(PINS)
  ) u_write_values (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(do_write && wsel == SEL_WRITE_VALUE && wstrb_reg[0]),
    .wr_idx_in(wpin),
    .wr_bit_in(wdata_reg[0]),
    .rd_idx_in(4'h0),
    .rd_bit_out(),
    .values_out(override_value)
  );

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < PINS; i++) begin
        cfg_reg[i] <= 4'h0;
      end
    end else if (do_write && wsel == SEL_CONFIG && wstrb_reg[0] && int'(wpin) < PINS) begin
      cfg_reg[wpin] <= wdata_reg[3:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pdm_reg[0] <= PDM_RESET;
      pdm_reg[1] <= PDM_RESET;
    end else if (do_write && wsel == SEL_PDM) begin
      for (int b = 0; b < 2; b++) begin
        if (wstrb_reg[b]) begin
          pdm_reg[awaddr_reg[2]][8*b +: 8] <= wdata_reg[8*b +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and core values
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < PINS; p++) begin : g_cfg
      assign multipurpose_select_out[p] = cfg_reg[p][0];
      assign pin_function_select_out[3*p +: 3] = cfg_reg[p][3:1];
    end
  endgenerate

  mp_pin_sampler #(
    .PINS(PINS)
  ) u_sampler (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_level_in(pin_level_in),
    .multipurpose_select_in(multipurpose_select_out),
    .pin_function_select_in(pin_function_select_out),
    .pin_override_value_in(override_value),
    .pin_sampled_value_out(sampled),
    .core_value_out(core_value_out)
  );

  // ----------------------------------------------------------------
  // pdm control outputs
  // ----------------------------------------------------------------
  assign pdm_mic_control_ch01_out = pdm_reg[0];
  assign pdm_mic_control_ch23_out = pdm_reg[1];

  generate
    for (genvar m = 0; m < 2; m++) begin : g_hpf
      logic [2:0] corner;
      assign corner = pdm_reg[m][CORNER_MSB:CORNER_LSB];
      assign highpass_enable_out[m] = pdm_reg[m][HIGHPASS_BIT];
      // corner reaches the filter only while enabled; 111 clamps to lowest corner
      assign highpass_corner_out[3*m +: 3] = !pdm_reg[m][HIGHPASS_BIT] ? 3'h0 :
        (corner == CORNER_RESERVED) ? CORNER_SAFE : corner;
    end
  endgenerate

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_DATA = 2'b10
  } rstate_t;

  rstate_t rstate_reg;
  sel_t rsel;
  logic [3:0] rpin;
  logic [15:0] rword;

  assign s_axi_arready_out = (rstate_reg == R_IDLE);
  assign rsel = decode(s_axi_araddr_in);
  assign rpin = pin_of(s_axi_araddr_in);

  always_comb begin
    rword = ZERO16;
    case (rsel)
      SEL_READ_VALUE: rword = {15'h0000, (int'(rpin) < PINS) ? sampled[rpin] : 1'b0};
      SEL_CONFIG: rword = (int'(rpin) < PINS) ? {12'h000, cfg_reg[rpin]} : ZERO16;
      SEL_PDM: rword = pdm_reg[s_axi_araddr_in[2]];
      default: rword = ZERO16; // write-only registers read zero
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rstate_reg <= R_IDLE;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= RESP_OKAY;
    end else begin
      case (rstate_reg)
        R_IDLE: begin
          if (s_axi_arvalid_in) begin
            rstate_reg <= R_DATA;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= {16'h0000, rword};
            s_axi_rresp_out <= (rsel == SEL_NONE || rsel == SEL_WRITE_VALUE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        R_DATA: begin
          if (s_axi_rready_in) begin
            rstate_reg <= R_IDLE;
            s_axi_rvalid_out <= 1'b0;
          end
        end
        default: begin
          rstate_reg <= R_IDLE;
          s_axi_rvalid_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // mp_pin_regs

// [rtl/mp_pin_pkg.sv]
// constants for the multipurpose pin value and pdm mic control block
// assumes a 40 MHz core clock and an axi4-lite register port
//
// Notes on behaviour
// - fourteen write-value registers, consecutive indices
// - function code 001 feeds written value to core
// - bit 0 override value, write-only, resets zero
// - fourteen read-only registers report input pin levels
// - read bit 0 pin level, upper bits zero
// - two mic control registers: ch01, ch23
// - mic control 16 bits, reset 0x4000
// - corner field acts only with highpass enable
// - corner halves per code, 59.9 to 0.93
// - code 001 input passes, overridable by write
// - select bit 0 keeps primary function
package mp_pin_pkg;
  localparam int NUM_PINS = 14;
  localparam int ADDR_W = 18;
  // printed offsets are indices; byte address is four times the index
  localparam logic [15:0] WRITE_VALUE_BASE_IDX = 16'hF520;
  localparam logic [15:0] WRITE_VALUE_LAST_IDX = 16'hF52D;
  localparam logic [15:0] READ_VALUE_BASE_IDX = 16'hF530;
  localparam logic [15:0] READ_VALUE_LAST_IDX = 16'hF53D;
  localparam logic [15:0] PDM_CH01_IDX = 16'hF560;
  localparam logic [15:0] PDM_CH23_IDX = 16'hF561;
  // pin configuration registers, one per pin
  localparam logic [15:0] PIN_CONFIG_BASE_IDX = 16'hF540;
  localparam logic [15:0] PIN_CONFIG_LAST_IDX = 16'hF54D;
  localparam logic [15:0] PDM_RESET = 16'h4000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam int CORNER_MSB = 14;
  localparam int CORNER_LSB = 12;
  localparam int HIGHPASS_BIT = 3;
  localparam logic [2:0] CORNER_RESERVED = 3'h7;
  localparam logic [2:0] CORNER_SAFE = 3'h6;
  localparam logic [2:0] FUNC_GP_INPUT = 3'h0;
  localparam logic [2:0] FUNC_PORT_DRIVEN = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/mp_value_bank.sv]
// per-pin value register bank with registered read data
// assumes writes and reads come from one bus slave
`timescale 1ns/1ps
module mp_value_bank
  import mp_pin_pkg::*;
#(
  parameter int DEPTH = NUM_PINS
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_idx_in,
  input wire logic wr_bit_in,
  input wire logic [3:0] rd_idx_in,
  output logic rd_bit_out,
  output logic [DEPTH-1:0] values_out
);
  initial begin
    if (DEPTH < 1 || DEPTH > 16) begin
      $error("depth out of range");
    end
  end

  logic [DEPTH-1:0] mem_reg;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mem_reg <= '0;
    end else if (wr_en_in && (int'(wr_idx_in) < DEPTH)) begin
      mem_reg[wr_idx_in] <= wr_bit_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_bit_out <= 1'b0;
    end else begin
      rd_bit_out <= (int'(rd_idx_in) < DEPTH) ? mem_reg[rd_idx_in] : 1'b0;
    end
  end

  assign values_out = mem_reg;
endmodule // mp_value_bank

// [rtl/mp_pin_sampler.sv]
// registers pin inputs and forms values seen by the dsp core
// assumes pin inputs synchronous to clk_in
`timescale 1ns/1ps
module mp_pin_sampler
  import mp_pin_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [PINS-1:0] pin_level_in,
  input wire logic [PINS-1:0] multipurpose_select_in,
  input wire logic [3*PINS-1:0] pin_function_select_in,
  input wire logic [PINS-1:0] pin_override_value_in,
  output logic [PINS-1:0] pin_sampled_value_out,
  output logic [PINS-1:0] core_value_out
);
  function automatic logic is_input(input logic [2:0] f);
    return (f == FUNC_GP_INPUT) || (f == FUNC_PORT_DRIVEN);
  endfunction

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic [2:0] func;
      assign func = pin_function_select_in[3*g +: 3];
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          pin_sampled_value_out[g] <= 1'b0;
          core_value_out[g] <= 1'b0;
        end else begin
          if (multipurpose_select_in[g] && is_input(func)) begin
            pin_sampled_value_out[g] <= pin_level_in[g];
          end
          if (!multipurpose_select_in[g]) begin
            core_value_out[g] <= 1'b0;
          end else if (func == FUNC_PORT_DRIVEN) begin
            core_value_out[g] <= pin_override_value_in[g];
          end else begin
            core_value_out[g] <= pin_level_in[g];
          end
        end
      end
    end
  endgenerate
endmodule // mp_pin_sampler

// [verification/mp_pin_regs_monitor.sv]
// checker for the pin value and pdm mic control register block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module mp_pin_regs_monitor
  import mp_pin_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [PINS-1:0] core_value_out,
  input wire logic [PINS-1:0] multipurpose_select_out,
  input wire logic [15:0] pdm_mic_control_ch01_out,
  input wire logic [15:0] pdm_mic_control_ch23_out,
  input wire logic [1:0] highpass_enable_out,
  input wire logic [5:0] highpass_corner_out
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  bresp_hold_a:
    assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  rdata_hold_a:
    assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  read_answer_a:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  write_answer_a:
    assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  write_refuse_a:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");
  pdm_reset_a:
    assert property (!$past(resetn_in) |-> pdm_mic_control_ch01_out == PDM_RESET
      && pdm_mic_control_ch23_out == PDM_RESET) else $error("mic control reset value wrong");
  hpf_enable_a:
    assert property (highpass_enable_out == {pdm_mic_control_ch23_out[3], pdm_mic_control_ch01_out[3]})
    else $error("highpass enable wrong");
  corner_ch01_a:
    assert property ($stable(pdm_mic_control_ch01_out) |-> highpass_corner_out[2:0] == (!pdm_mic_control_ch01_out[3]
      ? 3'h0 : (pdm_mic_control_ch01_out[14:12] == CORNER_RESERVED ? CORNER_SAFE : pdm_mic_control_ch01_out[14:12])))
    else $error("corner ch01 wrong");
  corner_ch23_a:
    assert property ($stable(pdm_mic_control_ch23_out) |-> highpass_corner_out[5:3] == (!pdm_mic_control_ch23_out[3]
      ? 3'h0 : (pdm_mic_control_ch23_out[14:12] == CORNER_RESERVED ? CORNER_SAFE : pdm_mic_control_ch23_out[14:12])))
    else $error("corner ch23 wrong");
  core_off_a:
    assert property ((core_value_out & ~$past(multipurpose_select_out)) == '0)
    else $error("core value seen on primary-function pin");
endmodule // mp_pin_regs_monitor

bind mp_pin_regs mp_pin_regs_monitor #(.PINS(PINS)) u_monitor (.clk_in(clk_in), .resetn_in(resetn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .core_value_out(core_value_out), .multipurpose_select_out(multipurpose_select_out),
  .pdm_mic_control_ch01_out(pdm_mic_control_ch01_out), .pdm_mic_control_ch23_out(pdm_mic_control_ch23_out),
  .highpass_enable_out(highpass_enable_out), .highpass_corner_out(highpass_corner_out));

// [verification/pin_drive_model.sv]
// external pin driver: presents requested levels on the pins
// assumes requests change just after a clock edge
`timescale 1ns/1ps
module pin_drive_model
  import mp_pin_pkg::*;
(
  input wire logic clk_in,
  input wire logic [NUM_PINS-1:0] level_req_in,
  output logic [NUM_PINS-1:0] pin_level_out
);
  // pins settle one edge after a request
  always_ff @(posedge clk_in) begin
    pin_level_out <= level_req_in;
  end
endmodule // pin_drive_model

// [verification/testbench.sv]
// testbench: axi4-lite master, expectation queues, pin driver
// assumes mp_pin_regs as top and pin_drive_model on the pins
`timescale 1ns/1ps
module testbench;
  import mp_pin_pkg::*;
  logic clk_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NUM_PINS-1:0] level_req, pin_level, core_value, lvl;
  logic [33:0] exp_b[$], exp_r[$];
  logic [31:0] r;
  logic [15:0] v;
  logic [5:0] corner;
  logic [2:0] ec;
  int error_cnt, samples_checked;
  mp_pin_regs dut (.clk_in(clk_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pin_level_in(pin_level),
    .core_value_out(core_value), .multipurpose_select_out(), .pin_function_select_out(),
    .pdm_mic_control_ch01_out(), .pdm_mic_control_ch23_out(), .highpass_enable_out(), .highpass_corner_out(corner));
  pin_drive_model pins (.clk_in(clk_in), .level_req_in(level_req), .pin_level_out(pin_level));
  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic cmp_word(input string what, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_bit(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    exp_b.push_back({32'h0, er});
    @(posedge clk_in);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [15:0] idx, input logic [33:0] e);
    exp_r.push_back(e);
    @(posedge clk_in);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // result watcher: oldest note against each answer
  always @(posedge clk_in) begin
    if (bvalid === 1'b1 && bready === 1'b1) cmp_word("bresp", exp_b.pop_front(), {32'h0, bresp});
    if (rvalid === 1'b1 && rready === 1'b1) cmp_word("read", exp_r.pop_front(), {rresp, rdata});
  end
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    end_sim();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {resetn_in, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, level_req} = '0;
    wstrb = 4'hF;
    void'($urandom(72018));
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    axi_rd(PDM_CH01_IDX, {RESP_OKAY, 16'h0, PDM_RESET});
    axi_rd(PDM_CH23_IDX, {RESP_OKAY, 16'h0, PDM_RESET});
    axi_rd(READ_VALUE_LAST_IDX, {RESP_OKAY, 32'h0});
    axi_rd(WRITE_VALUE_LAST_IDX, {RESP_SLVERR, 32'h0});
    axi_rd(16'h0000, {RESP_SLVERR, 32'h0});
    axi_wr(READ_VALUE_BASE_IDX, 32'h1, RESP_SLVERR);
    for (int p = 0; p < NUM_PINS; p++) begin
      axi_wr(PIN_CONFIG_BASE_IDX + 16'(p), 32'h1, RESP_OKAY);
      lvl = NUM_PINS'($urandom());
      level_req <= lvl;
      repeat (4) @(posedge clk_in);
      axi_rd(READ_VALUE_BASE_IDX + 16'(p), {RESP_OKAY, 31'h0, lvl[p]});
      r = $urandom();
      axi_wr(PIN_CONFIG_BASE_IDX + 16'(p), 32'h3, RESP_OKAY);
      axi_wr(WRITE_VALUE_BASE_IDX + 16'(p), r, RESP_OKAY);
      repeat (3) @(posedge clk_in);
      cmp_bit("core_value", r[0], core_value[p]);
      level_req <= ~lvl;
      repeat (4) @(posedge clk_in);
      cmp_bit("core_value", r[0], core_value[p]);
    end
    axi_wr(PIN_CONFIG_BASE_IDX, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk_in);
    cmp_bit("core_value", 1'b0, core_value[0]);
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? 16'h7008 : 16'($urandom());
      axi_wr(PDM_CH01_IDX + 16'(i % 2), {16'h0, v}, RESP_OKAY);
      axi_rd(PDM_CH01_IDX + 16'(i % 2), {RESP_OKAY, 16'h0, v});
      ec = !v[HIGHPASS_BIT] ? 3'h0 : ((v[CORNER_MSB:CORNER_LSB] == 3'h7) ? 3'h6 : v[CORNER_MSB:CORNER_LSB]);
      cmp_word("corner", 34'(ec), 34'(corner[3*(i%2) +: 3]));
    end
    // reset in mid-run restores mic control defaults
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    axi_rd(PDM_CH01_IDX, {RESP_OKAY, 16'h0, PDM_RESET});
    axi_rd(PDM_CH23_IDX, {RESP_OKAY, 16'h0, PDM_RESET});
    end_sim();
  end
endmodule // testbench
